// File: swt_pkg.sv
/*
 * Shared constants and types of the suspend wake-up timer.
 * Assumes one 20 MHz clock that keeps running while the core is halted.
 */
package swt_pkg;
    localparam int CLK_HZ            = 20_000_000;
    localparam int CLK_NS            = 50;
    localparam int TICK_S            = 1;
    localparam int SEC_CYCLES        = TICK_S * CLK_HZ;
    localparam int WAKE_DELAY_CYCLES = 1024;
    localparam int LBR_SETTLE_NS     = 5000;
    localparam int LBR_SETTLE_CYCLES = (LBR_SETTLE_NS + CLK_NS - 1) / CLK_NS;

    localparam logic [7:0] IDX_PORTC    = 8'h16;
    localparam logic [7:0] IDX_INTERVAL = 8'h20;
    localparam logic [7:0] IDX_WAKE     = 8'h21;
    localparam logic [7:0] IDX_CFG      = 8'h22;
    localparam logic [7:0] IDX_WAKE_EN  = 8'h23;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h24;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h25;

    localparam int PORTC_AMP_DIS  = 0;
    localparam int PORTC_LBR_CTL  = 1;
    localparam int PORTC_CONV_EN  = 7;
    localparam int STAT_LBAT      = 0;
    localparam int STAT_LBR_RDY   = 1;
    localparam int STAT_LOWV      = 2;
    localparam int WK_INTERVAL    = 0;
    localparam int WK_PORT        = 1;
    localparam int WK_INT         = 2;
    localparam int WK_WDT         = 3;
    localparam int WK_MOUSE       = 4;
    localparam int CFG_LOWV_EN    = 0;
    localparam int CFG_WDT_EN     = 1;
    localparam int CFG_MOUSE      = 2;
    localparam int IRQ_INTERVAL   = 0;
    localparam int IRQ_WAKE       = 1;
    localparam int IRQ_LOWV       = 2;
    localparam int IRQ_LBR        = 3;

    localparam logic [7:0] PORTC_RESET = 8'h81;
    localparam logic [7:0] CFG_RESET   = 8'h01;
    localparam logic [7:0] ZERO8       = 8'h00;
    localparam logic [7:0] EDGE2_PINS  = 8'h30;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_SUSPEND = 2'b01,
        ST_WAKE    = 2'b10
    } swt_state_t;

    typedef struct packed {
        logic [11:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [11:0] araddr;
        logic        arvalid;
        logic        rready;
    } swt_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } swt_axi_rsp_t;
endpackage : swt_pkg

// File: swt_timer.sv
/*
 * Suspend wake-up timer with port C control and status, behind AXI4-Lite.
 * Assumes mclk keeps running in suspend; the core presents a one-cycle
 * haltExec pulse and stops itself while cpuHalted is high.
 */
// The implementer's own choice: the AXI4-Lite interface to the registers.
// What this block does
// RULE1 - Interval counter runs in suspend and wakes the core like a port wake.
// RULE2 - A wake caused by the interval sets the interval wake flag.
// RULE3 - Interval register is eight read/write bits, one second per count.
// RULE4 - Interval zero gives no timed wake; mode picks the remaining sources.
// RULE5 - Nonzero interval: port, watchdog, interrupt, reset or period ends suspend.
// RULE6 - Reading port C clears its status bits five to seven.
// RULE7 - Converter off while halted blocks the low-voltage reset.
// RULE8 - Low-voltage trip resets the core only when the option enables it.
// RULE9 - Firmware waits the settling time after raising the battery read control.
// RULE10 - Port C bit zero turns the transmit amplifier off.
// RULE11 - Port A pins wake per enable; pins four and five on both edges.
// RULE12 - Every wake waits 1024 clocks before the core resumes.
// RULE13 - Suspend is entered only by the halt instruction.
// RULE14 - Interval count restarts at suspend entry, ticking once per second.
module swt_timer #(
    parameter int unsigned TICK_CYCLES = swt_pkg::SEC_CYCLES
) (
    input  wire logic                   mclk,
    input  wire logic                   rst_b,
    input  wire swt_pkg::swt_axi_req_t  axiReq,
    output swt_pkg::swt_axi_rsp_t       axiRsp,
    input  wire logic [7:0]             portAPins,
    input  wire logic                   extIntPin,
    input  wire logic                   motionDetect,
    input  wire logic                   buttonLevel,
    input  wire logic                   lowBatteryDetector,
    input  wire logic                   lowVoltageResetMonitor,
    input  wire logic                   wdtExpire,
    input  wire logic                   haltExec,
    output logic                        cpuHalted,
    output logic                        wakeResume,
    output logic                        cpuResetReq,
    output logic                        amplifierDisableBit,
    output logic                        converterEnableBit,
    output logic                        lowBatteryReadControl,
    output logic                        irq
);
    localparam int PW = $clog2(TICK_CYCLES);
    localparam int SW = $clog2(swt_pkg::LBR_SETTLE_CYCLES + 1);
    localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);
    localparam logic [SW-1:0] LBR_LAST  = SW'(swt_pkg::LBR_SETTLE_CYCLES - 1);
    localparam logic [9:0] WAKE_LAST = 10'(swt_pkg::WAKE_DELAY_CYCLES - 1);

    function automatic logic [7:0] regIdx(input logic [11:0] a);
        regIdx = a[9:2];
    endfunction : regIdx

    function automatic logic isMapped(input logic [11:0] a);
        logic [7:0] i;
        i = regIdx(a);
        isMapped = (a[11:10] == 2'h0) &&
                   (i == swt_pkg::IDX_PORTC || (i >= swt_pkg::IDX_INTERVAL &&
                    i <= swt_pkg::IDX_IRQ_MASK));
    endfunction : isMapped

    // Pins and detector outputs are asynchronous; stage three only feeds edge logic.
    logic [12:0] syncA, syncB, syncC;
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            syncA <= 13'h0000;
            syncB <= 13'h0000;
            syncC <= 13'h0000;
        end else begin
            syncA <= {lowVoltageResetMonitor, lowBatteryDetector, buttonLevel,
                      motionDetect, extIntPin, portAPins};
            syncB <= syncA;
            syncC <= syncB;
        end
    end

    logic [7:0] pinFall, pinRise;
    logic       intFall, mouseEvt, lowBatSync, lowvSync;
    assign pinFall    = syncC[7:0] & ~syncB[7:0];
    assign pinRise    = ~syncC[7:0] & syncB[7:0];
    assign intFall    = syncC[8] & ~syncB[8];
    assign mouseEvt   = (~syncC[9] & syncB[9]) | (syncC[10] ^ syncB[10]);
    assign lowBatSync = syncB[11];
    assign lowvSync   = syncB[12];

    swt_pkg::swt_state_t state;
    logic [7:0]    suspendWakeInterval, cfg, wakeEn, irqStat, irqMask;
    logic [7:0]    portCCtl;
    logic [2:0]    portCReadClearStatus;
    logic [4:0]    wakeCause;
    logic [PW-1:0] prescale;
    logic [7:0]    secCount;
    logic [9:0]    wakeCnt;
    logic [SW-1:0] settleCnt;

    logic secTick, timerHit, portWake, wdtWake, nonZero, mouseMode;
    logic anyWake, lvrHit, lbrDone;
    assign secTick   = (prescale == TICK_LAST);
    assign nonZero   = (suspendWakeInterval != swt_pkg::ZERO8);
    assign mouseMode = cfg[swt_pkg::CFG_MOUSE];
    assign timerHit  = (state == swt_pkg::ST_SUSPEND) && secTick && nonZero &&
                       (8'(secCount + 8'h01) == suspendWakeInterval); // RULE1 RULE3 RULE4
    assign portWake  = |(wakeEn & pinFall) |
                       |(wakeEn & pinRise & swt_pkg::EDGE2_PINS); // RULE11
    assign wdtWake   = wdtExpire && cfg[swt_pkg::CFG_WDT_EN];

    logic [4:0] cause;
    always_comb begin
        cause = 5'h00;
        if (mouseMode) begin
            cause[swt_pkg::WK_MOUSE] = mouseEvt; // RULE4
        end else begin
            cause[swt_pkg::WK_PORT] = portWake; // RULE4
            cause[swt_pkg::WK_INT]  = intFall;
        end
        if (nonZero) begin
            cause[swt_pkg::WK_PORT]     = portWake; // RULE5
            cause[swt_pkg::WK_INT]      = intFall;
            cause[swt_pkg::WK_WDT]      = wdtWake;
            cause[swt_pkg::WK_INTERVAL] = timerHit;
        end
    end
    assign anyWake = (state == swt_pkg::ST_SUSPEND) && (cause != 5'h00);

    // The timed wake joins the same wake path as the port pins.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state      <= swt_pkg::ST_RUN;
            cpuHalted  <= 1'b0;
            wakeResume <= 1'b0;
            wakeCnt    <= 10'h000;
            wakeCause  <= 5'h00;
        end else begin
            wakeResume <= 1'b0;
            unique case (state)
                swt_pkg::ST_RUN: begin
                    if (haltExec) begin
                        state     <= swt_pkg::ST_SUSPEND; // RULE13
                        cpuHalted <= 1'b1;
                        wakeCause <= 5'h00;
                    end
                end
                swt_pkg::ST_SUSPEND: begin
                    if (anyWake) begin
                        state     <= swt_pkg::ST_WAKE; // RULE1
                        wakeCnt   <= 10'h000;
                        wakeCause <= cause; // RULE2
                    end
                end
                swt_pkg::ST_WAKE: begin
                    wakeCnt <= 10'(wakeCnt + 10'h001);
                    if (wakeCnt == WAKE_LAST) begin
                        state      <= swt_pkg::ST_RUN; // RULE12
                        cpuHalted  <= 1'b0;
                        wakeResume <= 1'b1;
                    end
                end
                default: begin
                    state     <= swt_pkg::ST_RUN;
                    cpuHalted <= 1'b0;
                end
            endcase
        end
    end

    // The prescaler restarts at entry so the first interval is a full second.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            prescale <= '0;
            secCount <= 8'h00;
        end else if (state != swt_pkg::ST_SUSPEND) begin
            prescale <= '0; // RULE14
            secCount <= 8'h00;
        end else begin
            prescale <= secTick ? '0 : PW'(prescale + 1'b1); // RULE14
            if (secTick) begin
                secCount <= 8'(secCount + 8'h01);
            end
        end
    end

    // Settling count for the battery read; firmware should poll the ready bit.
    assign lbrDone = portCCtl[swt_pkg::PORTC_LBR_CTL] && (settleCnt == LBR_LAST); // RULE9
    always_ff @(posedge mclk) begin
        if (!rst_b || !portCCtl[swt_pkg::PORTC_LBR_CTL]) begin
            settleCnt <= '0;
        end else if (settleCnt <= LBR_LAST) begin
            settleCnt <= SW'(settleCnt + 1'b1);
        end
    end

    assign lvrHit = lowvSync && cfg[swt_pkg::CFG_LOWV_EN] && // RULE8
                    !(!portCCtl[swt_pkg::PORTC_CONV_EN] && cpuHalted); // RULE7
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cpuResetReq <= 1'b0;
        end else begin
            cpuResetReq <= lvrHit; // RULE8
        end
    end

    // Bus slave: one write and one read in flight, address and data in any order.
    logic        awHeld, wHeld, doWrite, rdTake, rdPortC;
    logic [11:0] awAddrQ;
    logic [31:0] wDataQ;
    logic        wLane0;
    logic [7:0]  wIdx, wByte;
    assign doWrite = awHeld && wHeld && !axiRsp.bvalid;
    assign wIdx    = regIdx(awAddrQ);
    assign wByte   = wDataQ[7:0];
    assign rdTake  = axiReq.arvalid && axiRsp.arready;
    assign rdPortC = rdTake && isMapped(axiReq.araddr) &&
                     regIdx(axiReq.araddr) == swt_pkg::IDX_PORTC;

    function automatic logic wrHit(input logic [7:0] idx);
        wrHit = doWrite && wLane0 && isMapped(awAddrQ) && (wIdx == idx);
    endfunction : wrHit

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            axiRsp.awready <= 1'b1;
            axiRsp.wready  <= 1'b1;
            axiRsp.bvalid  <= 1'b0;
            axiRsp.bresp   <= swt_pkg::RESP_OKAY;
            awHeld         <= 1'b0;
            wHeld          <= 1'b0;
            awAddrQ        <= 12'h000;
            wDataQ         <= 32'h0000_0000;
            wLane0         <= 1'b0;
        end else begin
            if (axiReq.awvalid && axiRsp.awready) begin
                awHeld         <= 1'b1;
                awAddrQ        <= axiReq.awaddr;
                axiRsp.awready <= 1'b0;
            end
            if (axiReq.wvalid && axiRsp.wready) begin
                wHeld         <= 1'b1;
                wDataQ        <= axiReq.wdata;
                wLane0        <= axiReq.wstrb[0];
                axiRsp.wready <= 1'b0;
            end
            if (doWrite) begin
                axiRsp.bvalid <= 1'b1;
                axiRsp.bresp  <= isMapped(awAddrQ) ? swt_pkg::RESP_OKAY
                                                   : swt_pkg::RESP_SLVERR;
            end
            if (axiRsp.bvalid && axiReq.bready) begin
                axiRsp.bvalid  <= 1'b0;
                awHeld         <= 1'b0;
                wHeld          <= 1'b0;
                axiRsp.awready <= 1'b1;
                axiRsp.wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            axiRsp.arready <= 1'b1;
            axiRsp.rvalid  <= 1'b0;
            axiRsp.rdata   <= 32'h0000_0000;
            axiRsp.rresp   <= swt_pkg::RESP_OKAY;
        end else if (rdTake) begin
            axiRsp.arready <= 1'b0;
            axiRsp.rvalid  <= 1'b1;
            axiRsp.rresp   <= isMapped(axiReq.araddr) ? swt_pkg::RESP_OKAY
                                                      : swt_pkg::RESP_SLVERR;
            unique case (isMapped(axiReq.araddr) ? regIdx(axiReq.araddr) : 8'hFF)
                swt_pkg::IDX_PORTC:    axiRsp.rdata <= {24'h0, portCReadClearStatus,
                                                        portCCtl[4:0]};
                swt_pkg::IDX_INTERVAL: axiRsp.rdata <= {24'h0, suspendWakeInterval};
                swt_pkg::IDX_WAKE:     axiRsp.rdata <= {27'h0, wakeCause};
                swt_pkg::IDX_CFG:      axiRsp.rdata <= {24'h0, cfg};
                swt_pkg::IDX_WAKE_EN:  axiRsp.rdata <= {24'h0, wakeEn};
                swt_pkg::IDX_IRQ_STAT: axiRsp.rdata <= {24'h0, irqStat};
                swt_pkg::IDX_IRQ_MASK: axiRsp.rdata <= {24'h0, irqMask};
                default:               axiRsp.rdata <= 32'h0000_0000;
            endcase
        end else if (axiRsp.rvalid && axiReq.rready) begin
            axiRsp.rvalid  <= 1'b0;
            axiRsp.arready <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            suspendWakeInterval <= 8'h00;
            cfg                 <= swt_pkg::CFG_RESET;
            wakeEn              <= 8'h00;
            irqMask             <= 8'h00;
            portCCtl            <= swt_pkg::PORTC_RESET;
        end else begin
            if (wrHit(swt_pkg::IDX_INTERVAL)) suspendWakeInterval <= wByte; // RULE3
            if (wrHit(swt_pkg::IDX_CFG))      cfg     <= wByte;
            if (wrHit(swt_pkg::IDX_WAKE_EN))  wakeEn  <= wByte; // RULE11
            if (wrHit(swt_pkg::IDX_IRQ_MASK)) irqMask <= wByte;
            if (wrHit(swt_pkg::IDX_PORTC))    portCCtl <= wByte;
        end
    end

    // A status set in the same cycle as the clearing read survives it.
    logic [2:0] statSet;
    assign statSet = {lvrHit, lbrDone, lbrDone && lowBatSync};
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            portCReadClearStatus <= 3'h0;
        end else begin
            portCReadClearStatus <= (portCReadClearStatus & ~{3{rdPortC}}) | statSet; // RULE6
        end
    end

    logic [7:0] irqEvt, next_irqStat;
    always_comb begin
        irqEvt = 8'h00;
        irqEvt[swt_pkg::IRQ_INTERVAL] = timerHit;
        irqEvt[swt_pkg::IRQ_WAKE]     = anyWake;
        irqEvt[swt_pkg::IRQ_LOWV]     = lvrHit;
        irqEvt[swt_pkg::IRQ_LBR]      = lbrDone;
        next_irqStat = irqStat;
        if (wrHit(swt_pkg::IDX_IRQ_STAT)) begin
            next_irqStat = irqStat & ~wByte;
        end
        next_irqStat = next_irqStat | irqEvt;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irqStat               <= 8'h00;
            irq                   <= 1'b0;
            amplifierDisableBit   <= 1'b1;
            converterEnableBit    <= 1'b1;
            lowBatteryReadControl <= 1'b0;
        end else begin
            irqStat               <= next_irqStat;
            irq                   <= |(next_irqStat & irqMask);
            amplifierDisableBit   <= portCCtl[swt_pkg::PORTC_AMP_DIS]; // RULE10
            converterEnableBit    <= portCCtl[swt_pkg::PORTC_CONV_EN];
            lowBatteryReadControl <= portCCtl[swt_pkg::PORTC_LBR_CTL];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_WAKE_LEN: assert property (state == swt_pkg::ST_WAKE && wakeCnt == WAKE_LAST |=> // RULE12
        !cpuHalted && wakeResume) else $error("wake delay end wrong");
    AST_WAKE_HOLD: assert property ($rose(state == swt_pkg::ST_WAKE) |-> // RULE12
        wakeCnt == 10'h000 && cpuHalted) else $error("wake delay start wrong");
    AST_ZERO_NONE: assert property (state == swt_pkg::ST_SUSPEND && !nonZero |=> // RULE4
        !wakeCause[swt_pkg::WK_INTERVAL]) else $error("timed wake with zero interval");
    AST_FLAG_SET: assert property (timerHit |=> wakeCause[swt_pkg::WK_INTERVAL] && // RULE2
        state == swt_pkg::ST_WAKE) else $error("interval flag not set");
    AST_PORT_WAKE: assert property (state == swt_pkg::ST_SUSPEND && portWake // RULE11
        && !mouseMode |=> state == swt_pkg::ST_WAKE) else $error("port wake missed");
    AST_RD_CLEAR: assert property (rdPortC && statSet == 3'h0 |=> // RULE6
        portCReadClearStatus == 3'h0) else $error("status not cleared");
    AST_LOWV_BLOCK: assert property (!portCCtl[swt_pkg::PORTC_CONV_EN] && cpuHalted // RULE7
        |=> !cpuResetReq) else $error("reset while converter off");
    AST_LOWV_RESET: assert property (lowvSync && cfg[swt_pkg::CFG_LOWV_EN] && !cpuHalted // RULE8
        |=> cpuResetReq) else $error("low-voltage reset missed");
    AST_ENTRY: assert property ($rose(state == swt_pkg::ST_SUSPEND) |-> // RULE13 RULE14
        $past(haltExec) && secCount == 8'h00) else $error("bad suspend entry");
    AST_AMP: assert property (wrHit(swt_pkg::IDX_PORTC) |=> ##1 // RULE10
        amplifierDisableBit == $past(wByte[0], 2)) else $error("amp bit not applied");

    COV_TIMED: cover property (timerHit ##1 state == swt_pkg::ST_WAKE);
    COV_RESUME: cover property (wakeResume);
    COV_LOWV: cover property (cpuResetReq);
    COV_LBR: cover property (lbrDone);
endmodule : swt_timer

// File: swt_timer_tb.sv
/*
 * Self-checking bench of the suspend wake-up timer: AXI4-Lite master tasks,
 * a queue of expected bus answers and pin stimulus around one instance.
 * Assumes swt_pkg and swt_timer are compiled first; one 20 MHz clock.
 */
module swt_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // A short second keeps each timed wake near a thousand cycles.
    localparam int          TK    = 16;
    localparam logic [11:0] A_PC  = {2'b00, swt_pkg::IDX_PORTC, 2'b00};
    localparam logic [11:0] A_IV  = {2'b00, swt_pkg::IDX_INTERVAL, 2'b00};
    localparam logic [11:0] A_WK  = {2'b00, swt_pkg::IDX_WAKE, 2'b00};
    localparam logic [11:0] A_CFG = {2'b00, swt_pkg::IDX_CFG, 2'b00};
    localparam logic [11:0] A_EN  = {2'b00, swt_pkg::IDX_WAKE_EN, 2'b00};
    localparam logic [11:0] A_ST  = {2'b00, swt_pkg::IDX_IRQ_STAT, 2'b00};
    localparam logic [11:0] A_MK  = {2'b00, swt_pkg::IDX_IRQ_MASK, 2'b00};
    localparam logic [1:0]  OK    = swt_pkg::RESP_OKAY;
    logic                  mclk, rst_b, haltExec, wdtExpire, extIntPin, lowBat, lowVolt;
    logic                  motion, button;
    logic [7:0]            portA, rndVal;
    logic                  cpuHalted, wakeResume, cpuResetReq, ampDis, convEn, lbrCtl, irq;
    swt_pkg::swt_axi_req_t req;
    swt_pkg::swt_axi_rsp_t rsp;
    logic [33:0]           notes[$];
    int                    fails, checks_done, cyc;

    swt_timer #(.TICK_CYCLES(TK)) u_dut (
        .mclk                  (mclk),
        .rst_b                 (rst_b),
        .axiReq                (req),
        .axiRsp                (rsp),
        .portAPins             (portA),
        .extIntPin             (extIntPin),
        .motionDetect          (motion),
        .buttonLevel           (button),
        .lowBatteryDetector    (lowBat),
        .lowVoltageResetMonitor(lowVolt),
        .wdtExpire             (wdtExpire),
        .haltExec              (haltExec),
        .cpuHalted             (cpuHalted),
        .wakeResume            (wakeResume),
        .cpuResetReq           (cpuResetReq),
        .amplifierDisableBit   (ampDis),
        .converterEnableBit    (convEn),
        .lowBatteryReadControl (lbrCtl),
        .irq                   (irq)
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    // Watcher: every bus answer is matched against the oldest note.
    always @(posedge mclk) begin
        if (rsp.rvalid === 1'b1 && req.rready === 1'b1)
            chk({rsp.rresp, rsp.rdata}, notes.pop_front());
        if (rsp.bvalid === 1'b1 && req.bready === 1'b1)
            chk({rsp.bresp, 32'h0}, notes.pop_front());
        cyc++;
        if (cyc == 30000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        bit aDone, wDone;
        notes.push_back({r, 32'h0});
        @(posedge mclk);
        req.awaddr  <= a;
        req.awvalid <= 1'b1;
        req.wdata   <= {24'h0, d};
        req.wstrb   <= 4'hF;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        do begin
            @(posedge mclk);
            aDone |= rsp.awready === 1'b1;
            wDone |= rsp.wready === 1'b1;
            if (aDone) req.awvalid <= 1'b0;
            if (wDone) req.wvalid <= 1'b0;
        end while (!(aDone && wDone));
        while (rsp.bvalid !== 1'b1) @(posedge mclk);
        req.bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        notes.push_back({r, 24'h0, d});
        @(posedge mclk);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        do @(posedge mclk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        while (rsp.rvalid !== 1'b1) @(posedge mclk);
        req.rready <= 1'b0;
    endtask : rd

    task automatic halt();
        @(posedge mclk);
        haltExec <= 1'b1;
        @(posedge mclk);
        haltExec <= 1'b0;
        @(posedge mclk);
        chk(34'(cpuHalted), 34'h1);
    endtask : halt

    // Counts halted cycles; the resume pulse must meet the falling edge.
    task automatic waitWake(input int lo);
        int n;
        n = 0;
        while (cpuHalted === 1'b1 && n < 5000) begin
            @(posedge mclk);
            n++;
        end
        chk(34'(n >= lo && n <= lo + 8), 34'h1);
        chk(34'(wakeResume), 34'h1);
    endtask : waitWake

    initial begin
        req = '0;
        {rst_b, haltExec, wdtExpire, lowBat, lowVolt, motion, button, portA} = '0;
        extIntPin = 1'b1;
        rndVal = 8'($urandom(32'h34C6));
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        chk(34'({ampDis, convEn, lbrCtl, irq}), 34'hC);
        rd(A_PC, 8'h01, OK);
        rd(A_CFG, swt_pkg::CFG_RESET, OK);
        rd(12'hFFC, 8'h00, swt_pkg::RESP_SLVERR);
        wr(A_IV, rndVal, OK);
        rd(A_IV, rndVal, OK);
        wr(A_PC, 8'h80, OK);
        repeat (2) @(posedge mclk);
        chk(34'(ampDis), 34'h0);
        wr(A_PC, 8'h81, OK);
        $display("registers test done");
        wr(A_IV, 8'h02, OK);
        wr(A_MK, 8'h03, OK);
        halt();
        waitWake(2 * TK + 1022);
        rd(A_WK, 8'h01, OK);
        chk(34'(irq), 34'h1);
        rd(A_ST, 8'h03, OK);
        wr(A_ST, 8'h03, OK);
        repeat (2) @(posedge mclk);
        chk(34'(irq), 34'h0);
        $display("timed wake test done");
        wr(A_IV, 8'h00, OK);
        wr(A_EN, 8'h10, OK);
        wr(A_CFG, 8'h03, OK);
        for (int k = 0; k < 3; k++) begin
            if (k == 2) wr(A_IV, 8'hC8, OK);
            halt();
            portA[0] <= ~portA[0];
            repeat (3 * TK) @(posedge mclk);
            chk(34'(cpuHalted), 34'h1);
            case (k)
                0: portA[4] <= 1'b1;
                1: extIntPin <= 1'b0;
                default: wdtExpire <= 1'b1;
            endcase
            @(posedge mclk);
            wdtExpire <= 1'b0;
            waitWake(1024);
            rd(A_WK, 8'h02 << k, OK);
            extIntPin <= 1'b1;
        end
        $display("wake source test done");
        // Mouse mode with a zero interval ignores the enabled port pin.
        wr(A_IV, 8'h00, OK);
        wr(A_CFG, 8'h04, OK);
        halt();
        portA[4] <= 1'b0;
        repeat (3 * TK) @(posedge mclk);
        chk(34'(cpuHalted), 34'h1);
        button <= 1'b1;
        waitWake(1020);
        rd(A_WK, 8'h10, OK);
        $display("mouse mode test done");
        lowBat <= 1'b1;
        wr(A_PC, 8'h83, OK);
        @(posedge mclk);
        chk(34'(lbrCtl), 34'h1);
        repeat (swt_pkg::LBR_SETTLE_CYCLES + 10) @(posedge mclk);
        wr(A_PC, 8'h81, OK);
        rd(A_PC, 8'h61, OK);
        rd(A_PC, 8'h01, OK);
        $display("read clear test done");
        wr(A_CFG, 8'h00, OK);
        lowVolt <= 1'b1;
        repeat (8) @(posedge mclk);
        chk(34'(cpuResetReq), 34'h0);
        lowVolt <= 1'b0;
        wr(A_CFG, 8'h01, OK);
        wr(A_PC, 8'h01, OK);
        halt();
        chk(34'(convEn), 34'h0);
        lowVolt <= 1'b1;
        repeat (8) @(posedge mclk);
        chk(34'(cpuResetReq), 34'h0);
        lowVolt <= 1'b0;
        extIntPin <= 1'b0;
        waitWake(1020);
        extIntPin <= 1'b1;
        wr(A_PC, 8'h81, OK);
        lowVolt <= 1'b1;
        repeat (8) @(posedge mclk);
        chk(34'(cpuResetReq), 34'h1);
        $display("low voltage test done");
        end_of_test();
    end
endmodule : swt_timer_tb
